/* File: hdl/plss_defs.svh */
// Purpose: constants for the process loop sleep/wake sequencer
// Assumes: 32-bit aligned register words on an AXI4-Lite slave
// Notes: offsets are byte addresses
`ifndef PLSS_DEFS_SVH
`define PLSS_DEFS_SVH
`define PLSS_OFF_CTRL 8'h00
`define PLSS_OFF_PRE_FREQ 8'h04
`define PLSS_OFF_PRE_EXIT 8'h08
`define PLSS_OFF_PRE_DELAY 8'h0c
`define PLSS_OFF_SLP_DELAY 8'h10
`define PLSS_OFF_SLP_FREQ 8'h14
`define PLSS_OFF_WAKE_LVL 8'h18
`define PLSS_OFF_UNIT 8'h1c
`define PLSS_OFF_GAIN 8'h20
`define PLSS_OFF_ALT_GAIN 8'h24
`define PLSS_OFF_STATUS 8'h28
`define PLSS_OFF_IRQ_STAT 8'h2c
`define PLSS_OFF_IRQ_MASK 8'h30
`define PLSS_OFF_DISPLAY 8'h34
`define PLSS_OFF_MFI_FUNC 8'h38
`define PLSS_FN_BYPASS 8'h17
`define PLSS_FN_ALT_GAIN 8'h18
`define PLSS_UNIT_CELSIUS 5'h0b
`define PLSS_UNIT_FAHRENHEIT 5'h0c
`define PLSS_UNIT_MAX 5'h10
`define PLSS_WAKE_BELOW 2'h0
`define PLSS_WAKE_ABOVE 2'h1
`define PLSS_WAKE_BEYOND 2'h2
`define PLSS_TICK_DIV 16'h4e20
`define PLSS_RESP_OKAY 2'h0
`define PLSS_RESP_SLVERR 2'h2
`define PLSS_IRQ_FAULT 0
`define PLSS_IRQ_SLEEP 1
`define PLSS_IRQ_WAKE 2
`endif

/* File: hdl/plss_pkg.sv */
// Purpose: types for the process loop sleep/wake sequencer
// Assumes: one-hot state codes
// Notes: all module state is one packed struct
package plss_pkg;
	typedef enum logic [4:0] {
		PLSS_IDLE = 5'h01,
		PLSS_PRE = 5'h02,
		PLSS_RUN = 5'h04,
		PLSS_SLEEP = 5'h08,
		PLSS_FAULT = 5'h10
	} plss_state_t;
	typedef struct packed {
		logic [15:0] pre_loop_frequency;
		logic [15:0] pre_loop_exit_level;
		logic [15:0] pre_loop_fail_delay;
		logic [15:0] sleep_delay_time;
		logic [15:0] sleep_frequency;
		logic [15:0] wake_level;
		logic [1:0] wake_condition_mode;
		logic [4:0] display_unit_select;
		logic [15:0] display_unit_gain;
		logic [15:0] display_unit_scale;
		logic [15:0] loop_proportional_gain;
		logic [15:0] loop_integral_time;
		logic [15:0] alternate_loop_gain;
		logic [7:0] alt_gain_input_function;
		logic [7:0] loop_bypass_input_function;
		logic [2:0] irq_mask;
	} plss_cfg_t;
	typedef struct packed {
		logic aw_done;
		logic w_done;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} plss_bus_t;
	typedef struct packed {
		plss_cfg_t cfg;
		plss_bus_t bus;
		plss_state_t state;
		logic [15:0] div_cnt;
		logic [15:0] timer;
		logic [2:0] irq_stat;
		logic fault;
		logic [15:0] freq_cmd;
		logic [15:0] prop_gain;
		logic [15:0] int_time;
		logic [31:0] display_value;
		logic [2:0] mfi_s1;
		logic [2:0] mfi_s2;
	} plss_st_t;
endpackage

/* File: hdl/plss_seq.sv */
// Purpose: sequencer around a process feedback loop: pre-loop ramp, sleep, wake, bypass
// Assumes: feedback, reference and frequency come from same-clock logic; pins are async
// Notes: the loop arithmetic itself lives outside; this block picks gains and states
//
// Functional notes
// R1 - unit code 11 Celsius, 12 Fahrenheit
// R2 - scale display value by unit gain, scale
// R3 - function 24 input selects alternate gain
// R4 - run first ramps open-loop to pre-loop frequency
// R5 - closed loop once feedback exceeds exit level
// R6 - feedback low for whole delay trips fault
// R7 - low frequency for sleep delay enters sleep
// R8 - sleep raises warning without tripping
// R9 - wake mode 0: feedback below wake level
// R10 - wake mode 1: feedback above wake level
// R11 - wake mode 2: reference minus feedback exceeds level
// R12 - function 23 input bypasses loop while asserted
// R13 - one exclusive state machine, bypass has priority
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "plss_defs.svh"
module plss_seq
	import plss_pkg::*;
#(
	parameter int TICK_DIV = `PLSS_TICK_DIV,
	parameter int NUM_MFI = 3
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic run_cmd_in,
	input wire logic [NUM_MFI-1:0] mfi_pin_in,
	input wire logic [15:0] feedback_in,
	input wire logic [15:0] reference_in,
	input wire logic [15:0] out_freq_in,
	output logic [15:0] freq_cmd_out,
	output logic loop_enable_out,
	output logic output_enable_out,
	output logic [15:0] prop_gain_out,
	output logic [15:0] int_time_out,
	output logic pre_loop_failure_fault_out,
	output logic sleep_warning_code_out,
	output logic [31:0] display_value_out,
	output logic unit_is_celsius_out,
	output logic unit_is_fahrenheit_out,
	output logic irq_out
);
	// elaboration checks: divider needs a count, input bank fits the sampling vectors
	if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
		$error("TICK_DIV out of range");
	end
	if (NUM_MFI < 1 || NUM_MFI > 3) begin : g_bad_mfi
		$error("NUM_MFI must be 1 to 3");
	end
	localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);
	plss_st_t st_q;
	plss_st_t st_d;
	logic tick;
	logic [NUM_MFI-1:0] mfi_sync;
	logic alt_gain_on;
	logic bypass_on;
	logic wake_hit;
	logic [16:0] err;
	logic [31:0] rd_word;
	logic rd_ok;
	logic wr_fire;
	logic [2:0] irq_set;

	// true when the function setting equals the given code and any synchronised input is high
	function automatic logic mfi_has(input logic [NUM_MFI-1:0] act, input logic [7:0] fn,
		input logic [7:0] code);
		mfi_has = (fn == code) && (|act);
	endfunction

	// merge a write word under byte strobes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		wmerge = r;
	endfunction

	// pins pass two flops before use; only the second stage is read
	genvar g;
	generate
		for (g = 0; g < NUM_MFI; g++) begin : g_sync
			assign mfi_sync[g] = st_q.mfi_s2[g];
		end
	endgenerate

	assign tick = (st_q.div_cnt == TICK_LAST);
	assign alt_gain_on = mfi_has(mfi_sync,
		st_q.cfg.alt_gain_input_function, `PLSS_FN_ALT_GAIN); // R3
	assign bypass_on = mfi_has(mfi_sync,
		st_q.cfg.loop_bypass_input_function, `PLSS_FN_BYPASS); // R12
	assign err = {1'b0, reference_in} - {1'b0, feedback_in};
	// wake decision per mode; beyond mode ignores negative error
	always_comb begin
		case (st_q.cfg.wake_condition_mode)
			`PLSS_WAKE_BELOW: wake_hit = feedback_in < st_q.cfg.wake_level; // R9
			`PLSS_WAKE_ABOVE: wake_hit = feedback_in > st_q.cfg.wake_level; // R10
			`PLSS_WAKE_BEYOND: wake_hit = !err[16] && (err[15:0] > st_q.cfg.wake_level); // R11
			default: wake_hit = 1'b0;
		endcase
	end

	// read mux; unmapped addresses answer slverr with zero data
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (s_axi_araddr_in)
			`PLSS_OFF_CTRL: rd_word = {30'h0, st_q.cfg.wake_condition_mode};
			`PLSS_OFF_PRE_FREQ: rd_word = {16'h0, st_q.cfg.pre_loop_frequency};
			`PLSS_OFF_PRE_EXIT: rd_word = {16'h0, st_q.cfg.pre_loop_exit_level};
			`PLSS_OFF_PRE_DELAY: rd_word = {16'h0, st_q.cfg.pre_loop_fail_delay};
			`PLSS_OFF_SLP_DELAY: rd_word = {16'h0, st_q.cfg.sleep_delay_time};
			`PLSS_OFF_SLP_FREQ: rd_word = {16'h0, st_q.cfg.sleep_frequency};
			`PLSS_OFF_WAKE_LVL: rd_word = {16'h0, st_q.cfg.wake_level};
			`PLSS_OFF_UNIT: rd_word = {27'h0, st_q.cfg.display_unit_select};
			`PLSS_OFF_GAIN: rd_word = {st_q.cfg.loop_integral_time, st_q.cfg.loop_proportional_gain};
			`PLSS_OFF_ALT_GAIN: rd_word = {16'h0, st_q.cfg.alternate_loop_gain};
			`PLSS_OFF_STATUS: rd_word = {24'h0, bypass_on, alt_gain_on, 1'b0, st_q.state};
			`PLSS_OFF_IRQ_STAT: rd_word = {29'h0, st_q.irq_stat};
			`PLSS_OFF_IRQ_MASK: rd_word = {29'h0, st_q.cfg.irq_mask};
			`PLSS_OFF_DISPLAY: rd_word = {st_q.cfg.display_unit_scale, st_q.cfg.display_unit_gain};
			`PLSS_OFF_MFI_FUNC: rd_word = {16'h0, st_q.cfg.loop_bypass_input_function,
				st_q.cfg.alt_gain_input_function};
			default: rd_ok = 1'b0;
		endcase
	end

	assign wr_fire = st_q.bus.aw_done && st_q.bus.w_done && !st_q.bus.bvalid;
	// next state: bus slave, divider, sequencer, interrupts
	always_comb begin
		logic [31:0] w, prod;
		w = 32'h0000_0000;
		prod = 32'h0000_0000;
		st_d = st_q;
		irq_set = 3'h0;
		st_d.mfi_s1 = 3'(mfi_pin_in);
		st_d.mfi_s2 = st_q.mfi_s1;
		st_d.div_cnt = tick ? 16'h0000 : st_q.div_cnt + 16'h0001;

		// write channels taken in either order, response after both
		if (s_axi_awvalid_in && !st_q.bus.aw_done) begin
			st_d.bus.aw_done = 1'b1;
			st_d.bus.waddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !st_q.bus.w_done) begin
			st_d.bus.w_done = 1'b1;
			st_d.bus.wdata = s_axi_wdata_in;
			st_d.bus.wstrb = s_axi_wstrb_in;
		end
		if (wr_fire) begin
			st_d.bus.bvalid = 1'b1;
			st_d.bus.bresp = `PLSS_RESP_OKAY;
			case (st_q.bus.waddr)
				`PLSS_OFF_CTRL: begin
					w = wmerge({30'h0, st_q.cfg.wake_condition_mode}, st_q.bus.wdata, st_q.bus.wstrb);
					st_d.cfg.wake_condition_mode = w[1:0];
				end
				`PLSS_OFF_PRE_FREQ: begin
					w = wmerge(32'h0, st_q.bus.wdata, st_q.bus.wstrb);
					st_d.cfg.pre_loop_frequency = w[15:0];
				end
				`PLSS_OFF_PRE_EXIT: st_d.cfg.pre_loop_exit_level = st_q.bus.wdata[15:0];
				`PLSS_OFF_PRE_DELAY: st_d.cfg.pre_loop_fail_delay = st_q.bus.wdata[15:0];
				`PLSS_OFF_SLP_DELAY: st_d.cfg.sleep_delay_time = st_q.bus.wdata[15:0];
				`PLSS_OFF_SLP_FREQ: st_d.cfg.sleep_frequency = st_q.bus.wdata[15:0];
				`PLSS_OFF_WAKE_LVL: st_d.cfg.wake_level = st_q.bus.wdata[15:0];
				`PLSS_OFF_UNIT: begin
					if (st_q.bus.wdata[4:0] <= `PLSS_UNIT_MAX) begin
						st_d.cfg.display_unit_select = st_q.bus.wdata[4:0];
					end
				end
				`PLSS_OFF_GAIN: begin
					st_d.cfg.loop_proportional_gain = st_q.bus.wdata[15:0];
					st_d.cfg.loop_integral_time = st_q.bus.wdata[31:16];
				end
				`PLSS_OFF_ALT_GAIN: st_d.cfg.alternate_loop_gain = st_q.bus.wdata[15:0];
				`PLSS_OFF_IRQ_MASK: st_d.cfg.irq_mask = st_q.bus.wdata[2:0];
				`PLSS_OFF_DISPLAY: begin
					st_d.cfg.display_unit_gain = st_q.bus.wdata[15:0];
					st_d.cfg.display_unit_scale = st_q.bus.wdata[31:16];
				end
				`PLSS_OFF_MFI_FUNC: begin
					st_d.cfg.alt_gain_input_function = st_q.bus.wdata[7:0];
					st_d.cfg.loop_bypass_input_function = st_q.bus.wdata[15:8];
				end
				`PLSS_OFF_STATUS: st_d.fault = st_q.bus.wdata[0] ? 1'b0 : st_q.fault;
				default: st_d.bus.bresp = `PLSS_RESP_SLVERR;
			endcase
		end
		if (st_q.bus.bvalid && s_axi_bready_in) begin
			st_d.bus.bvalid = 1'b0;
			st_d.bus.aw_done = 1'b0;
			st_d.bus.w_done = 1'b0;
		end

		// read: one cycle to answer; reading the interrupt status clears it below
		if (s_axi_arvalid_in && !st_q.bus.rvalid) begin
			st_d.bus.rvalid = 1'b1;
			st_d.bus.rdata = rd_word;
			st_d.bus.rresp = rd_ok ? `PLSS_RESP_OKAY : `PLSS_RESP_SLVERR;
		end else if (st_q.bus.rvalid && s_axi_rready_in) begin
			st_d.bus.rvalid = 1'b0;
		end

		// sequencer advances once per control tick
		if (tick) begin
			case (st_q.state)
				PLSS_IDLE: begin
					st_d.timer = 16'h0000;
					if (run_cmd_in) begin
						st_d.state = PLSS_PRE;
					end
				end
				PLSS_PRE: begin
					st_d.timer = st_q.timer + 16'h0001;
					if (feedback_in > st_q.cfg.pre_loop_exit_level) begin
						st_d.state = PLSS_RUN; // R5
						st_d.timer = 16'h0000;
					end else if (st_q.cfg.pre_loop_fail_delay != 16'h0000 &&
						st_q.timer + 16'h0001 >= st_q.cfg.pre_loop_fail_delay) begin
						st_d.state = PLSS_FAULT; // R6
						st_d.fault = 1'b1;
						irq_set[`PLSS_IRQ_FAULT] = 1'b1;
					end
				end
				PLSS_RUN: begin
					// the count restarts whenever frequency climbs back, so low must be unbroken
					if (out_freq_in < st_q.cfg.sleep_frequency) begin
						st_d.timer = st_q.timer + 16'h0001;
						if (st_q.timer + 16'h0001 >= st_q.cfg.sleep_delay_time) begin
							st_d.state = PLSS_SLEEP; // R7
							irq_set[`PLSS_IRQ_SLEEP] = 1'b1; // R8
						end
					end else begin
						st_d.timer = 16'h0000;
					end
				end
				PLSS_SLEEP: begin
					st_d.timer = 16'h0000;
					if (wake_hit) begin
						st_d.state = PLSS_RUN;
						irq_set[`PLSS_IRQ_WAKE] = 1'b1;
					end
				end
				PLSS_FAULT: begin
					// fault holds until software clears it and run is dropped
					if (!st_q.fault && !run_cmd_in) begin
						st_d.state = PLSS_IDLE;
					end
				end
				default: st_d.state = PLSS_IDLE;
			endcase
			// run removed ends any non-fault state; fault stays latched
			if (!run_cmd_in && st_q.state != PLSS_FAULT) begin
				st_d.state = PLSS_IDLE;
			end
		end

		// frequency command: open-loop target during pre-loop and bypass
		if (bypass_on || st_q.state == PLSS_PRE) begin
			st_d.freq_cmd = st_q.cfg.pre_loop_frequency; // R4 R12
		end else begin
			st_d.freq_cmd = 16'h0000;
		end

		// gain selection for the outside loop arithmetic
		st_d.prop_gain = alt_gain_on ? st_q.cfg.alternate_loop_gain
			: st_q.cfg.loop_proportional_gain; // R3
		st_d.int_time = alt_gain_on ? st_q.cfg.alternate_loop_gain
			: st_q.cfg.loop_integral_time; // R3

		// display: feedback times unit gain over 2^(low five bits of unit scale)
		prod = 32'(feedback_in) * 32'(st_q.cfg.display_unit_gain);
		st_d.display_value = prod >> st_q.cfg.display_unit_scale[4:0]; // R2

		// sticky status: a read clears, but a same-cycle set wins
		if (s_axi_arvalid_in && !st_q.bus.rvalid && s_axi_araddr_in == `PLSS_OFF_IRQ_STAT) begin
			st_d.irq_stat = irq_set;
		end else begin
			st_d.irq_stat = st_q.irq_stat | irq_set;
		end
	end

	// single register bank for all state
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
			st_q.state <= PLSS_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// handshake outputs straight from flops (readies inverted), data from flops
	assign s_axi_awready_out = !st_q.bus.aw_done;
	assign s_axi_wready_out = !st_q.bus.w_done;
	assign s_axi_bvalid_out = st_q.bus.bvalid;
	assign s_axi_bresp_out = st_q.bus.bresp;
	assign s_axi_arready_out = !st_q.bus.rvalid;
	assign s_axi_rvalid_out = st_q.bus.rvalid;
	assign s_axi_rdata_out = st_q.bus.rdata;
	assign s_axi_rresp_out = st_q.bus.rresp;
	assign freq_cmd_out = st_q.freq_cmd;
	assign loop_enable_out = (st_q.state == PLSS_RUN) && !bypass_on; // R13 R12
	assign output_enable_out = bypass_on ? run_cmd_in && !st_q.fault
		: (st_q.state == PLSS_PRE) || (st_q.state == PLSS_RUN); // R6 R7 R13
	assign prop_gain_out = st_q.prop_gain;
	assign int_time_out = st_q.int_time;
	assign pre_loop_failure_fault_out = st_q.fault;
	assign sleep_warning_code_out = (st_q.state == PLSS_SLEEP); // R8
	assign display_value_out = st_q.display_value;
	assign unit_is_celsius_out = (st_q.cfg.display_unit_select == `PLSS_UNIT_CELSIUS); // R1
	assign unit_is_fahrenheit_out = (st_q.cfg.display_unit_select == `PLSS_UNIT_FAHRENHEIT); // R1
	assign irq_out = |(st_q.irq_stat & st_q.cfg.irq_mask);
endmodule

/* File: test/plss_plant.sv */
// Purpose: feedback transducer and motor seen by the sequencer
// Assumes: bench sets the feedback and the running speed levels
// Notes: no ramp is modelled; a blocked output stops the motor at once
`timescale 1ns/10ps
module plss_plant (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic output_enable_in,
	input wire logic [15:0] fb_level_in,
	input wire logic [15:0] speed_level_in,
	output logic [15:0] feedback_out,
	output logic [15:0] out_freq_out
);
	// one clock of transducer lag, so the design never sees a same-edge change
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			feedback_out <= 16'h0000;
			out_freq_out <= 16'h0000;
		end else begin
			feedback_out <= fb_level_in;
			out_freq_out <= output_enable_in ? speed_level_in : 16'h0000;
		end
	end
endmodule

/* File: test/plss_seq_properties.sv */
// Purpose: port-level checks for the process loop sleep/wake sequencer
// Assumes: bound into plss_seq; one clock domain, sync active-low reset
// Notes: settings live in registers unseen here, so checks tie outputs to each other
`timescale 1ns/10ps
module plss_seq_properties #(
	parameter int TICK_DIV = 4,
	parameter int NUM_MFI = 3
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic run_cmd_in,
	input wire logic [15:0] freq_cmd_out,
	input wire logic loop_enable_out,
	input wire logic output_enable_out,
	input wire logic pre_loop_failure_fault_out,
	input wire logic sleep_warning_code_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	// write answer needs one clock to see both halves taken, then one to register
	wr_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write answer late");
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write answer dropped");
	rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
		else $error("read answer dropped");
	// registered frequency may lag the state change by one clock
	loop_freq_a: assert property (loop_enable_out && $past(loop_enable_out)
		|-> freq_cmd_out == 16'h0000) else $error("open-loop frequency in closed loop");
	one_state_a: assert property (!(loop_enable_out && sleep_warning_code_out))
		else $error("loop and sleep together");
	sleep_no_trip_a: assert property (sleep_warning_code_out
		|-> !pre_loop_failure_fault_out) else $error("sleep tripped a fault");
	fault_blocks_a: assert property (pre_loop_failure_fault_out
		|-> !output_enable_out && !loop_enable_out) else $error("output live under fault");
	// the fault only clears through a write, which needs an address already taken
	fault_hold_a: assert property (pre_loop_failure_fault_out && s_axi_awready_out
		|=> pre_loop_failure_fault_out) else $error("fault lost");
	sleep_run_a: assert property ($rose(sleep_warning_code_out) |-> $past(run_cmd_in))
		else $error("sleep without run");
	cover property ($rose(sleep_warning_code_out));
	cover property ($rose(pre_loop_failure_fault_out));
	cover property ($fell(sleep_warning_code_out) && loop_enable_out);
endmodule
bind plss_seq plss_seq_properties #(.TICK_DIV(TICK_DIV), .NUM_MFI(NUM_MFI)) i_plss_seq_properties (.*);

/* File: test/plss_seq_tb_top.sv */
// Purpose: self-checking bench for the sleep/wake sequencer
// Assumes: TICK_DIV of 4, so one control tick is four clocks
// Notes: waits are whole ticks with one tick of margin for registered outputs
`timescale 1ns/10ps
`include "plss_defs.svh"
module plss_seq_tb_top;
	localparam int TD = 4;
	logic clk = 1'h0, rst_n = 1'h0, run = 1'h0;
	logic [2:0] mfi = 3'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic [31:0] wd = 32'h0, rdata, disp;
	logic [15:0] fbl = 16'h0, fql = 16'h0, refv = 16'h0, fb, ofq, fcmd, pg, it;
	logic awr, wrr, bv, arr, rv, le, oe, flt, sleep_warning_code, cel, fah, irq;
	logic [1:0] bresp, rresp;
	logic [15:0] hold[3] = '{16'h28, 16'h28, 16'h32};
	logic [15:0] wake[3] = '{16'h27, 16'h29, 16'h31};
	logic [15:0] refs[3] = '{16'h0, 16'h0, 16'h5a};
	int err_count = 0;
	int checks_done = 0;
	plss_seq #(.TICK_DIV(TD)) i_plss_seq (.clock_in(clk), .rst_n_in(rst_n),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rr), .run_cmd_in(run), .mfi_pin_in(mfi), .feedback_in(fb),
		.reference_in(refv), .out_freq_in(ofq), .freq_cmd_out(fcmd), .loop_enable_out(le),
		.output_enable_out(oe), .prop_gain_out(pg), .int_time_out(it),
		.pre_loop_failure_fault_out(flt), .sleep_warning_code_out(sleep_warning_code),
		.display_value_out(disp), .unit_is_celsius_out(cel), .unit_is_fahrenheit_out(fah),
		.irq_out(irq));
	plss_plant i_plss_plant (.clock_in(clk), .rst_n_in(rst_n), .output_enable_in(oe),
		.fb_level_in(fbl), .speed_level_in(fql), .feedback_out(fb), .out_freq_out(ofq));
	// free-running 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task give_verdict;
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task hung;
		err_count++;
		$display("BAD %0t bus timeout", $time);
		give_verdict;
	endtask
	task tk(input int n);
		repeat (n * TD) @(posedge clk);
	endtask
	// address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		int n;
		n = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (awv && awr) awv <= 1'h0;
			if (wv && wrr) wv <= 1'h0;
			if (n > 50) hung;
		end while (!(bv && br));
		br <= 1'h0;
		chk(bresp, er);
	endtask
	task rdw(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		int n;
		n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (arv && arr) arv <= 1'h0;
			if (n > 50) hung;
		end while (!(rv && rr));
		rr <= 1'h0;
		chk(rdata, e);
		chk(rresp, er);
	endtask
	task t_units;
		wr(`PLSS_OFF_UNIT, 32'hb);
		chk({cel, fah}, 32'h2);
		wr(`PLSS_OFF_UNIT, 32'hc);
		chk({cel, fah}, 32'h1);
		wr(`PLSS_OFF_DISPLAY, 32'h00010003);
		fbl <= 16'h64;
		tk(2);
		chk(disp, 32'h96);
		wr(8'h3c, 32'h5, `PLSS_RESP_SLVERR);
		rdw(8'h3c, 32'h0, `PLSS_RESP_SLVERR);
	endtask
	task t_alt;
		wr(`PLSS_OFF_GAIN, 32'h00070005);
		wr(`PLSS_OFF_ALT_GAIN, 32'h9);
		wr(`PLSS_OFF_MFI_FUNC, 32'h18);
		mfi <= 3'h4;
		tk(2);
		chk(pg, 32'h9);
		chk(it, 32'h9);
		mfi <= 3'h0;
		tk(2);
		chk(pg, 32'h5);
		chk(it, 32'h7);
		wr(`PLSS_OFF_MFI_FUNC, 32'h0);
	endtask
	task t_prefail;
		wr(`PLSS_OFF_PRE_FREQ, 32'h1e);
		wr(`PLSS_OFF_PRE_EXIT, 32'h32);
		wr(`PLSS_OFF_PRE_DELAY, 32'h3);
		wr(`PLSS_OFF_IRQ_MASK, 32'h6);
		fbl <= 16'ha;
		run <= 1'h1;
		tk(2);
		chk({fcmd, oe, le, flt}, {16'h1e, 3'h4});
		tk(4);
		chk({flt, oe, irq}, 32'h4);
		wr(`PLSS_OFF_IRQ_MASK, 32'h7);
		chk(irq, 32'h1);
		rdw(`PLSS_OFF_IRQ_STAT, 32'h1);
		rdw(`PLSS_OFF_IRQ_STAT, 32'h0);
		chk(irq, 32'h0);
		run <= 1'h0;
		wr(`PLSS_OFF_STATUS, 32'h1);
		tk(2);
		rdw(`PLSS_OFF_STATUS, 32'h1);
	endtask
	// feedback (mode 2: reference minus feedback) equal to the wake level must hold the sleep in every mode
	task t_sleep;
		wr(`PLSS_OFF_PRE_DELAY, 32'h0);
		wr(`PLSS_OFF_SLP_FREQ, 32'h14);
		wr(`PLSS_OFF_SLP_DELAY, 32'h3);
		wr(`PLSS_OFF_WAKE_LVL, 32'h28);
		fql <= 16'h64;
		fbl <= 16'h32;
		run <= 1'h1;
		tk(3);
		chk({le, fcmd}, 32'h1e);
		fbl <= 16'h33;
		tk(3);
		chk(le, 32'h1);
		for (int m = 0; m < 3; m++) begin
			wr(`PLSS_OFF_CTRL, 32'(m));
			refv <= refs[m];
			fbl <= hold[m];
			fql <= 16'ha;
			tk(1);
			chk(sleep_warning_code, 32'h0);
			tk(5);
			chk({sleep_warning_code, oe, flt, le}, 32'h8);
			fbl <= wake[m];
			fql <= 16'h64;
			tk(2);
			chk(le, 32'h1);
		end
		rdw(`PLSS_OFF_IRQ_STAT, 32'h6);
	endtask
	task t_bypass;
		wr(`PLSS_OFF_MFI_FUNC, 32'h1700);
		mfi <= 3'h1;
		tk(2);
		chk({le, oe, fcmd}, {2'h1, 16'h1e});
		rdw(`PLSS_OFF_STATUS, 32'h84);
		mfi <= 3'h0;
		tk(2);
		chk({le, fcmd}, 32'h10000);
		run <= 1'h0;
		tk(2);
		chk(oe, 32'h0);
	endtask
	// reset for three clocks, then each scenario in turn
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		t_units;
		t_alt;
		t_prefail;
		t_sleep;
		t_bypass;
		give_verdict;
	end
endmodule
